// >>> twc_pin_load.sv
// Load model for the waveform pin: external circuit with a pull-down
`timescale 1ns/100ps
module twc_pin_load (
  input  wire logic pinOut,
  input  wire logic pinOe_b,
  output logic      pinLevel
);
  // Released pin falls to the pull-down, never keeps the last value
  assign pinLevel = pinOe_b ? 1'b0 : pinOut;
endmodule

// >>> twc_pkg.sv
// Package for the timer waveform and compare output block
//
// Summary of operation
// - Nonzero action select puts the compare output latch onto the pin.
// - Pin direction stays with the direction bit; latch shows only as output.
// - Pin override depends on action select only, never on wave mode.
// - Software can preset the latch before enabling the pin driver.
// - Action select zero leaves the latch unchanged on a match.
// - New action select acts at next match; force strobe acts at once.
// - Wave mode alone sets the count sequence; action select never does.
// - Mode 0 always increments, wraps 0xFF to 0x00, no hardware clear.
// - Normal mode sets overflow as count becomes zero; counting never clears.
// - Overflow flag also clears when its interrupt is serviced.
// - Normal mode accepts count writes at any time.
// - Mode 2 clears count to zero when it equals the compare value.
// - Clear-on-match compare writes are direct; low value wraps via 0xFF.
// - Clear-on-match raises the match flag each time count hits top.
// - Clear-on-match with action 1 toggles the latch every match.
// - Clear-on-match sets overflow when count passes 0xFF to 0x00.
// - Mode 3 counts up to maximum then clears to bottom next tick.
// - Fast PWM action 2 clears on match, sets at bottom; 3 reverses.
// - Fast PWM sets overflow each time the counter wraps from maximum to bottom.
// - Fast PWM compare zero gives spike; compare maximum gives constant level.
// - Fast PWM action 1 toggles on match with compare buffering active.
// - Fast PWM period is exactly 256 timer ticks.
// - PWM compare value is buffered; mode 3 loads it at bottom, mode 1 never; others write direct.
// - Match flag is set one timer tick after count equals compare.
// - Force strobe outside PWM modes updates latch like a match, no flag, no counter change.
// - Count write blocks any compare match on the following timer tick.
package twc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_COUNT   = 8'h04;
  localparam logic [7:0] OFS_COMPARE = 8'h08;
  localparam logic [7:0] OFS_FLAGS   = 8'h0C;
  localparam logic [7:0] OFS_PORT    = 8'h10;
  localparam logic [7:0] OFS_LATCH   = 8'h14;

  // Field positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_ACT_LSB  = 2;
  localparam int unsigned CTRL_FORCE    = 4;
  localparam int unsigned FLAG_OVF      = 0;
  localparam int unsigned FLAG_MATCH    = 1;
  localparam int unsigned PORT_VAL      = 0;
  localparam int unsigned PORT_DIR      = 1;

  // Count extremes
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hFF;
  localparam logic [7:0] CNT_ONE    = 8'h01;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic       RST_BIT  = 1'b0;

  typedef enum logic [1:0] {
    WM_NORMAL = 2'b00,
    WM_DUAL   = 2'b01,
    WM_CLEAR  = 2'b10,
    WM_FAST   = 2'b11
  } twc_wave_e;

  typedef enum logic [1:0] {
    ACT_NONE   = 2'b00,
    ACT_TOGGLE = 2'b01,
    ACT_CLEAR  = 2'b10,
    ACT_SET    = 2'b11
  } twc_act_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } twc_req_s;

  typedef struct packed {
    logic [7:0] count;
    logic [7:0] cmpActive;
    logic [7:0] cmpBuffer;
    twc_wave_e  waveMode;
    twc_act_e   actSel;
    logic       overflowFlag;
    logic       matchFlag;
    logic       matchPend;
    logic       blockNext;
    logic       latch;
    logic       portVal;
    logic       pinDir;
    logic [7:0] rdata;
  } twc_state_s;

endpackage

// >>> twc_timer.sv
// Timer counter with compare match output and pin override
`timescale 1ns/100ps
module twc_timer
  import twc_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic             clkEn,
  input  wire logic             timerTick,
  input  wire twc_req_s         busReq,
  output logic      [7:0]       busRdata,
  input  wire logic             overflowAck,
  input  wire logic             matchAck,
  output logic                  overflowFlag,
  output logic                  matchFlag,
  output logic                  pinOut,
  output logic                  pinOe_b
);

  ////////////////////////////////////////////////////////////////////////////
  twc_state_s stQ;
  twc_state_s stD;

  function automatic logic applyAct(input twc_act_e act, input logic cur);
    logic res;
    res = cur;
    unique case (act)
      ACT_NONE:   res = cur;
      ACT_TOGGLE: res = ~cur;
      ACT_CLEAR:  res = 1'b0;
      ACT_SET:    res = 1'b1;
    endcase
    return res;
  endfunction

  function automatic logic isWrite(input twc_req_s r, input logic [7:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic tick;
  logic cntWr;
  logic cmpWr;
  logic ctrlWr;
  logic flagWr;
  logic isPwm;
  logic cmpEq;
  logic match;
  logic atMax;
  logic forceNow;

  always_comb begin
    tick     = timerTick;
    cntWr    = isWrite(busReq, OFS_COUNT);
    cmpWr    = isWrite(busReq, OFS_COMPARE);
    ctrlWr   = isWrite(busReq, OFS_CTRL);
    flagWr   = isWrite(busReq, OFS_FLAGS);
    isPwm    = stQ.waveMode[0];
    cmpEq    = (stQ.count == stQ.cmpActive);
    // A pending count write eats the match of the next tick
    match    = tick && cmpEq && !stQ.blockNext && !cntWr;
    atMax    = (stQ.count == CNT_MAX);
    forceNow = ctrlWr && busReq.wdata[CTRL_FORCE] && !isPwm;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    stD = stQ;

    // Counter sequence: wave mode only, action select not consulted
    if (tick) begin
      unique case (stQ.waveMode)
        WM_NORMAL, WM_DUAL: begin
          stD.count = stQ.count + CNT_ONE;
          if (atMax) begin
            stD.overflowFlag = 1'b1;
          end
        end
        WM_CLEAR: begin
          if (match) begin
            stD.count = CNT_BOTTOM;
          end else begin
            stD.count = stQ.count + CNT_ONE;
          end
          if (atMax && !match) begin
            stD.overflowFlag = 1'b1;
          end
        end
        WM_FAST: begin
          if (atMax) begin
            stD.count        = CNT_BOTTOM;
            stD.overflowFlag = 1'b1;
            stD.cmpActive    = stQ.cmpBuffer;
          end else begin
            stD.count = stQ.count + CNT_ONE;
          end
        end
      endcase
      stD.blockNext = 1'b0;
      // Flag follows the match by one tick
      stD.matchPend = match;
      if (stQ.matchPend) begin
        stD.matchFlag = 1'b1;
      end
    end

    // Latch actions; bottom set/clear after match so compare MAX is steady
    if (match) begin
      stD.latch = applyAct(stQ.actSel, stQ.latch);
    end
    if (tick && stQ.waveMode == WM_FAST && atMax) begin
      if (stQ.actSel == ACT_CLEAR) begin
        stD.latch = 1'b1;
      end else if (stQ.actSel == ACT_SET) begin
        stD.latch = 1'b0;
      end
    end
    if (forceNow) begin
      // Force uses the action select value just written
      stD.latch = applyAct(twc_act_e'(busReq.wdata[CTRL_ACT_LSB +: 2]),
                           stQ.latch);
    end

    // Software writes override counting
    if (ctrlWr) begin
      stD.waveMode = twc_wave_e'(busReq.wdata[CTRL_MODE_LSB +: 2]);
      stD.actSel   = twc_act_e'(busReq.wdata[CTRL_ACT_LSB +: 2]);
    end
    if (cntWr) begin
      stD.count     = busReq.wdata;
      stD.blockNext = 1'b1;
    end
    if (cmpWr) begin
      stD.cmpBuffer = busReq.wdata;
      if (!isPwm) begin
        stD.cmpActive = busReq.wdata;
      end
    end
    if (isWrite(busReq, OFS_LATCH)) begin
      stD.latch = busReq.wdata[0];
    end
    if (isWrite(busReq, OFS_PORT)) begin
      stD.portVal = busReq.wdata[PORT_VAL];
      stD.pinDir  = busReq.wdata[PORT_DIR];
    end

    // Clears lose against a set in the same cycle
    if ((flagWr && busReq.wdata[FLAG_OVF]) || overflowAck) begin
      stD.overflowFlag = 1'b0;
    end
    if ((flagWr && busReq.wdata[FLAG_MATCH]) || matchAck) begin
      stD.matchFlag = 1'b0;
    end
    if (tick && stD.count == CNT_BOTTOM && stQ.count == CNT_MAX
        && stQ.waveMode != WM_FAST) begin
      stD.overflowFlag = 1'b1;
    end
    if (tick && stQ.waveMode == WM_FAST && atMax) begin
      stD.overflowFlag = 1'b1;
    end
    if (tick && stQ.matchPend) begin
      stD.matchFlag = 1'b1;
    end

    // Read data valid the cycle after the strobe only
    stD.rdata = RST_BYTE;
    if (busReq.rd) begin
      unique case (busReq.addr)
        OFS_CTRL:    stD.rdata = {4'h0, stQ.actSel, stQ.waveMode};
        OFS_COUNT:   stD.rdata = stQ.count;
        OFS_COMPARE: stD.rdata = stQ.cmpBuffer;
        OFS_FLAGS:   stD.rdata = {6'h00, stQ.matchFlag, stQ.overflowFlag};
        OFS_PORT:    stD.rdata = {6'h00, stQ.pinDir, stQ.portVal};
        OFS_LATCH:   stD.rdata = {7'h00, stQ.latch};
        default:     stD.rdata = RST_BYTE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stQ <= '0;
    end else if (clkEn) begin
      stQ <= stD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    busRdata     = stQ.rdata;
    overflowFlag = stQ.overflowFlag;
    matchFlag    = stQ.matchFlag;
    // Override follows action select, independent of wave mode
    pinOut  = (stQ.actSel != ACT_NONE) ? stQ.latch : stQ.portVal;
    pinOe_b = ~stQ.pinDir;
  end

endmodule

// >>> twc_timer_bench.sv
// Self-checking bench for the timer waveform block
`timescale 1ns/100ps
module twc_timer_bench
  import twc_pkg::*;
;
  logic       core_clk, rst_b, clkEn, timerTick, overflowAck, matchAck;
  twc_req_s   busReq;
  logic [7:0] busRdata, cmp;
  logic       overflowFlag, matchFlag, pinOut, pinOe_b, pinLevel, ok;
  int         fail_count, tests_run, seed, ones;

  twc_timer uut (.core_clk(core_clk), .rst_b(rst_b), .clkEn(clkEn),
    .timerTick(timerTick), .busReq(busReq), .busRdata(busRdata),
    .overflowAck(overflowAck), .matchAck(matchAck),
    .overflowFlag(overflowFlag), .matchFlag(matchFlag), .pinOut(pinOut),
    .pinOe_b(pinOe_b));
  twc_pin_load load (.pinOut(pinOut), .pinOe_b(pinOe_b), .pinLevel(pinLevel));
  ////////////////////////////////////////////////////////////////////////////
  task final_report;
    if (fail_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    busReq.wr <= 1'b1;
    busReq.addr <= a;
    busReq.wdata <= d;
    @(posedge core_clk);
    busReq.wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    busReq.rd <= 1'b1;
    busReq.addr <= a;
    @(posedge core_clk);
    busReq.rd <= 1'b0;
    @(negedge core_clk);
    chk(busRdata, e);
    @(posedge core_clk);
  endtask
  // Idle cycles drop the clock enable at random to exercise the freeze
  task tick(input int n);
    repeat (n) begin
      timerTick <= 1'b1;
      clkEn <= 1'b1;
      @(posedge core_clk);
      timerTick <= 1'b0;
      clkEn <= 1'($random(seed));
      @(posedge core_clk);
    end
    clkEn <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    #160000;
    fail_count++;
    final_report;
  end
  initial begin
    seed = 32'hD917;
    {fail_count, tests_run, rst_b, timerTick, overflowAck, matchAck} = '0;
    busReq = '0;
    clkEn = 1'b1;
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    chk({pinOe_b, overflowFlag, matchFlag, pinOut}, 8'h08);
    rd(8'h20, 8'h00);
    wr(OFS_PORT, 8'h03);
    chk(pinLevel, 1'b1);
    wr(OFS_LATCH, 8'h00);
    wr(OFS_CTRL, 8'h04);
    chk(pinOut, 1'b0);
    wr(OFS_CTRL, 8'h06);
    chk(pinOut, 1'b0);
    wr(OFS_PORT, 8'h01);
    chk(pinLevel, 1'b0);
    wr(OFS_LATCH, 8'h01);
    chk(pinOut, 1'b1);
    wr(OFS_COUNT, 8'h30);
    wr(OFS_CTRL, 8'h14);
    chk({matchFlag, pinOut}, 8'h00);
    rd(OFS_COUNT, 8'h30);
    wr(OFS_CTRL, 8'h10);
    rd(OFS_LATCH, 8'h00);
    wr(OFS_COUNT, 8'hFE);
    tick(1);
    chk(overflowFlag, 1'b0);
    tick(1);
    chk(overflowFlag, 1'b1);
    rd(OFS_COUNT, 8'h00);
    overflowAck <= 1'b1;
    @(posedge core_clk);
    overflowAck <= 1'b0;
    @(posedge core_clk);
    chk(overflowFlag, 1'b0);
    // Clear-on-match: compare kept at 2 or more for the wrap case below
    cmp = 8'h02 + 8'($random(seed) & 15);
    wr(OFS_COMPARE, cmp);
    wr(OFS_LATCH, 8'h00);
    wr(OFS_CTRL, 8'h06);
    wr(OFS_FLAGS, 8'h03);
    wr(OFS_COUNT, 8'h00);
    tick(cmp + 1);
    rd(OFS_COUNT, 8'h00);
    chk({matchFlag, pinOut}, 8'h01);
    tick(1);
    chk(matchFlag, 1'b1);
    matchAck <= 1'b1;
    @(posedge core_clk);
    matchAck <= 1'b0;
    @(posedge core_clk);
    chk(matchFlag, 1'b0);
    wr(OFS_COUNT, cmp);
    tick(1);
    rd(OFS_COUNT, cmp + 8'h01);
    wr(OFS_COMPARE, 8'h02);
    tick(255 - cmp);
    chk(overflowFlag, 1'b1);
    rd(OFS_COUNT, 8'h00);
    for (int i = 0; i < 6; i++) begin
      cmp = i < 2 ? 8'h00 : i < 4 ? 8'hFF : 8'($random(seed));
      wr(OFS_CTRL, i[0] ? 8'h0F : 8'h0B);
      wr(OFS_COMPARE, cmp);
      wr(OFS_COUNT, 8'hFE);
      wr(OFS_FLAGS, 8'h01);
      tick(2);
      chk(overflowFlag, 1'b1);
      ones = 0;
      repeat (256) begin
        tick(1);
        ones += int'(pinOut);
      end
      ok = i[0] ? (ones == 255 - cmp || cmp == 8'hFF && ones == 256)
                : ones == cmp + 1;
      chk(ok, 1'b1);
      rd(OFS_COUNT, 8'h00);
    end
    // Toggle in fast PWM: one period holds exactly one match
    wr(OFS_LATCH, 8'h00);
    wr(OFS_CTRL, 8'h07);
    tick(256);
    chk(pinOut, 1'b1);
    // Mode 3 is still in force and PWM class, so the force strobe must be ignored
    wr(OFS_CTRL, 8'h15);
    rd(OFS_LATCH, 8'h01);
    final_report;
  end
endmodule

// >>> twc_timer_checker.sv
// Port checker for the timer waveform block
`timescale 1ns/100ps
module twc_timer_checker
  import twc_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic       clkEn,
  input wire logic       timerTick,
  input wire twc_req_s   busReq,
  input wire logic [7:0] busRdata,
  input wire logic       overflowAck,
  input wire logic       matchAck,
  input wire logic       overflowFlag,
  input wire logic       matchFlag,
  input wire logic       pinOut,
  input wire logic       pinOe_b
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_rdPort;
    clkEn && busReq.rd && busReq.addr == OFS_PORT;
  endsequence
  property p_pinSrc;
    $changed(pinOut) |-> $past(busReq.wr || timerTick);
  endproperty
  property p_dirHold;
    $changed(pinOe_b) |-> $past(busReq.wr && busReq.addr == OFS_PORT);
  endproperty
  property p_dirRead;
    s_rdPort |=> busRdata[PORT_DIR] == !pinOe_b;
  endproperty
  property p_ovfRise;
    $rose(overflowFlag) |-> $past(clkEn && timerTick);
  endproperty
  property p_matchRise;
    $rose(matchFlag) |-> $past(clkEn && timerTick);
  endproperty
  property p_ovfFall;
    $fell(overflowFlag) |-> $past(clkEn && (overflowAck || busReq.wr
      && busReq.addr == OFS_FLAGS && busReq.wdata[FLAG_OVF]));
  endproperty
  property p_matchFall;
    $fell(matchFlag) |-> $past(clkEn && (matchAck || busReq.wr
      && busReq.addr == OFS_FLAGS && busReq.wdata[FLAG_MATCH]));
  endproperty
  property p_ackClr;
    clkEn && overflowAck && !timerTick |=> !overflowFlag;
  endproperty
  property p_freeze;
    !clkEn |=> $stable({overflowFlag, matchFlag, pinOut, pinOe_b});
  endproperty
  a_pinSrc: assert property (p_pinSrc)
    else $error("pin output moved without a cause");
  a_dirHold: assert property (p_dirHold)
    else $error("pin enable moved without a port write");
  a_dirRead: assert property (p_dirRead)
    else $error("direction readback differs from pin enable");
  a_ovfRise: assert property (p_ovfRise)
    else $error("overflow flag set off a timer tick");
  a_matchRise: assert property (p_matchRise)
    else $error("match flag set off a timer tick");
  a_ovfFall: assert property (p_ovfFall)
    else $error("overflow flag cleared without a clear");
  a_matchFall: assert property (p_matchFall)
    else $error("match flag cleared without a clear");
  a_ackClr: assert property (p_ackClr)
    else $error("overflow service did not clear the flag");
  a_freeze: assert property (p_freeze)
    else $error("state moved while the clock enable was low");
endmodule

bind twc_timer twc_timer_checker u_chk (.core_clk(core_clk), .rst_b(rst_b),
  .clkEn(clkEn), .timerTick(timerTick), .busReq(busReq),
  .busRdata(busRdata), .overflowAck(overflowAck), .matchAck(matchAck),
  .overflowFlag(overflowFlag), .matchFlag(matchFlag), .pinOut(pinOut),
  .pinOe_b(pinOe_b));
